// ===== logic/remote_wake_pkg.sv
// constants, field layouts and types of the remote wake and phy power sequencer
// Contract
// RULE_01: static power event output stays asserted until chip reset returns.
// RULE_02: reset with strap high re-enters the default wake ready mode.
// RULE_03: reset with strap low starts normal operation and usb attach at once.
// RULE_04: ready mode needs config bits 15:12 equal to 0111, static active high.
// RULE_05: ready mode leaves both usb data lines undriven.
// RULE_06: strap low: host resume wakes; device wake gated by allow, feature, enables. The external pin wake is gated by allow and feature only.
// RULE_07: strap high: magic packet, secondary link change, external pulse always wake.
// RULE_08: full phy power-down stops oscillator, pll, bandgap for at least 500ns.
// RULE_09: basic mode power-down keeps oscillator and pll, turns bandgap off.
// RULE_10: phy_deep_powerdown bit of register 0x20 selects full power-down.
// RULE_11: 600ms stabilisation after power-up before any phy reset takes effect.
// RULE_12: a low phy_rst_release during stabilisation is kept low beyond it.
// RULE_13: after stabilisation the phy is held in reset at least 500ns.
// RULE_14: software phy reset pulses last at least 500ns.
// RULE_15: ready mode keeps magic detector, phy and autonegotiation enabled.
// RULE_16: after asserting the power event, ready mode exits to normal operation.
// RULE_17: ready mode usable only when config bit 0 selects self-powered.
// RULE_18: power-down, stabilisation and reset intervals counted, rounded up.
// RULE_19: external wake synchronised; low pulse counts once on its rising edge.
package remote_wake_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_WORD_ADDR = 8'h00;
    localparam logic [7:0] WAKE_CTRL_ADDR = 8'h04;
    localparam logic [7:0] EVT_STATUS_ADDR = 8'h08;
    localparam logic [7:0] EVT_CLEAR_ADDR = 8'h0c;
    localparam logic [7:0] EVT_ENABLE_ADDR = 8'h10;
    localparam logic [7:0] STATE_ADDR = 8'h14;
    localparam logic [7:0] PHY_MODE_ADDR = 8'h18;
    localparam logic [7:0] SOFT_RESET_ADDR = 8'h20;

    typedef struct packed {
        logic wake_indicate_cfg;
        logic wake_out_type_cfg;
        logic wake_out_polarity_cfg;
        logic wake_pin_select_cfg;
        logic [9:0] spare;
        logic remote_wake_allow;
        logic self_powered;
    } cfg_word_type;

    typedef struct packed {
        logic [3:0] spare;
        logic set_feature;
        logic wake_on_linkchg_en;
        logic wake_on_magic_en;
        logic wake_on_pattern_en;
    } wake_ctrl_type;

    typedef struct packed {
        logic [5:0] spare;
        logic phy_deep_powerdown;
        logic phy_rst_release;
    } soft_reset_type;

    localparam logic [15:0] CFG_RESET = 16'h7001;
    localparam logic [3:0] READY_CFG_BITS = 4'h7;
    localparam logic [7:0] WAKE_CTRL_RESET = 8'h00;
    localparam logic [7:0] SOFT_RESET_RESET = 8'h01;
    localparam int BMCR_PD_BIT = 11;
    localparam int EVT_W = 3;
    localparam int EVT_WAKE = 0;
    localparam int EVT_READY_EXIT = 1;
    localparam int EVT_PHY_UP = 2;

    typedef enum logic [1:0] {
        MODE_RESET = 2'b00,
        MODE_READY = 2'b01,
        MODE_NORMAL = 2'b10
    } mode_type;

    typedef enum logic [1:0] {
        PHY_DOWN = 2'b00,
        PHY_STAB = 2'b01,
        PHY_HOLD = 2'b10,
        PHY_ON = 2'b11
    } phy_state_type;

    // timing
    localparam longint CLK_PERIOD_PS = 64'd4000;
    localparam longint PD_MIN_NS = 64'd500;
    localparam longint RST_MIN_NS = 64'd500;
    localparam longint STAB_MS = 64'd600;
    localparam longint PULSE_NS = 64'd1000;
    localparam int TIMER_W = 28;
    localparam logic [TIMER_W-1:0] PD_CYCLES =
        TIMER_W'((PD_MIN_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
    localparam logic [TIMER_W-1:0] RST_CYCLES =
        TIMER_W'((RST_MIN_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
    localparam logic [TIMER_W-1:0] PULSE_CYCLES =
        TIMER_W'((PULSE_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
    localparam int STAB_CYCLES_DEFAULT =
        int'((STAB_MS * 64'd1000000000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
endpackage

// ===== logic/interval_timer.sv
// down counter that measures one interval from a start pulse
`timescale 1ns/1ps
module interval_timer #(
    parameter int W = 28
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // control
    input wire logic start_in,
    input wire logic [W-1:0] length_in,
    // status
    output logic busy_out,
    output logic done_out
);
    logic [W-1:0] count;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            count <= '0;
        end else if (start_in) begin
            count <= length_in;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign busy_out = (count != '0);
    assign done_out = (count == W'(1));
endmodule

// ===== logic/remote_wake_phy_power_seq.sv
// remote wake, power event output and phy power and reset sequencer
`timescale 1ns/1ps
module remote_wake_phy_power_seq #(
    parameter int STAB_CYCLES = remote_wake_pkg::STAB_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // pins
    input wire logic wol_strap_in,
    input wire logic external_wake_in,
    // wake sources from same clock
    input wire logic pattern_match_in,
    input wire logic magic_packet_in,
    input wire logic link_chg_primary_in,
    input wire logic link_chg_secondary_in,
    input wire logic host_resume_in,
    input wire logic usb_suspended_in,
    // power event and usb side
    output logic power_event_out,
    output logic remote_wake_req_out,
    output logic usb_line_drive_en_out,
    output logic usb_attach_en_out,
    output logic magic_det_en_out,
    output logic phy_en_out,
    output logic autoneg_en_out,
    output logic misc_func_en_out,
    // phy power and reset
    output logic osc_en_out,
    output logic pll_en_out,
    output logic bandgap_en_out,
    output logic phy_reset_out,
    // interrupt
    output logic irq_out
);
    remote_wake_pkg::cfg_word_type cfg;
    remote_wake_pkg::wake_ctrl_type wake_ctrl;
    remote_wake_pkg::soft_reset_type soft_rst;
    logic bmcr_pd;
    logic [remote_wake_pkg::EVT_W-1:0] evt_status;
    logic [remote_wake_pkg::EVT_W-1:0] evt_enable;
    logic [remote_wake_pkg::EVT_W-1:0] evt_set;
    remote_wake_pkg::mode_type mode;
    remote_wake_pkg::mode_type next_mode;
    remote_wake_pkg::phy_state_type phy_state;
    remote_wake_pkg::phy_state_type next_phy_state;
    logic strap_s1, strap_s2, strap_q;
    logic ext_s1, ext_s2, ext_s3, ext_evt;
    logic ready_ok, ready_wake, normal_wake, pme_active, pme_start;
    logic deep_req, rst_release_q, soft_start, soft_busy;
    logic seq_start, seq_busy, pulse_busy;
    logic [remote_wake_pkg::TIMER_W-1:0] seq_len;
    logic wr_en, setup;
    logic [31:0] next_rdata;
    logic next_err;

    // pin synchronisers
    always_ff @(posedge clock_in) begin
        strap_s1 <= wol_strap_in;
        strap_s2 <= strap_s1;
        ext_s1 <= external_wake_in;
        ext_s2 <= ext_s1;
        ext_s3 <= ext_s2;
    end

    // strap caught while reset is held
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            strap_q <= strap_s2;
        end
    end

    // rising return of the low wake pulse
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ext_evt <= 1'b0;
        end else begin
            ext_evt <= ext_s2 & ~ext_s3; // RULE_19
        end
    end

    assign ready_ok = strap_q && cfg.self_powered // RULE_17
        && (cfg[15:12] == remote_wake_pkg::READY_CFG_BITS); // RULE_04

    // wake decisions
    assign ready_wake = magic_packet_in | link_chg_secondary_in | ext_evt; // RULE_07
    assign normal_wake = usb_suspended_in && (host_resume_in // RULE_06
        || (cfg.remote_wake_allow && wake_ctrl.set_feature
        && ((pattern_match_in && wake_ctrl.wake_on_pattern_en)
        || (magic_packet_in && wake_ctrl.wake_on_magic_en)
        || ((link_chg_primary_in || link_chg_secondary_in)
        && wake_ctrl.wake_on_linkchg_en)
        || ext_evt)));
    assign pme_start = (mode == remote_wake_pkg::MODE_READY) ? ready_wake
        : ((mode == remote_wake_pkg::MODE_NORMAL) && normal_wake);

    // operating mode
    always_comb begin
        next_mode = mode;
        case (mode)
            remote_wake_pkg::MODE_RESET: begin
                next_mode = ready_ok ? remote_wake_pkg::MODE_READY // RULE_02
                    : remote_wake_pkg::MODE_NORMAL; // RULE_03
            end
            remote_wake_pkg::MODE_READY: begin
                if (pme_active) begin
                    next_mode = remote_wake_pkg::MODE_NORMAL; // RULE_16
                end
            end
            default: begin
                next_mode = remote_wake_pkg::MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mode <= remote_wake_pkg::MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // power event latch
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pme_active <= 1'b0;
        end else if (pme_start) begin
            pme_active <= 1'b1;
        end else if (!cfg.wake_out_type_cfg && !pulse_busy) begin
            pme_active <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            power_event_out <= ~cfg.wake_out_polarity_cfg;
            remote_wake_req_out <= 1'b0;
        end else begin
            power_event_out <= pme_active ~^ cfg.wake_out_polarity_cfg; // RULE_01
            remote_wake_req_out <= pme_start && (mode == remote_wake_pkg::MODE_NORMAL);
        end
    end

    interval_timer #(.W(remote_wake_pkg::TIMER_W)) pulse_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(pme_start),
        .length_in(remote_wake_pkg::PULSE_CYCLES),
        .busy_out(pulse_busy),
        .done_out()
    );

    // mode and phy state dependent enables
    assign usb_line_drive_en_out = (mode == remote_wake_pkg::MODE_NORMAL); // RULE_05
    assign usb_attach_en_out = (mode == remote_wake_pkg::MODE_NORMAL); // RULE_03
    assign misc_func_en_out = (mode == remote_wake_pkg::MODE_NORMAL);
    assign magic_det_en_out = (mode != remote_wake_pkg::MODE_RESET); // RULE_15
    assign autoneg_en_out = (mode != remote_wake_pkg::MODE_RESET);
    assign phy_en_out = (phy_state != remote_wake_pkg::PHY_DOWN);

    // ready mode keeps the phy up
    assign deep_req = soft_rst.phy_deep_powerdown // RULE_10
        && (mode != remote_wake_pkg::MODE_READY); // RULE_15

    // phy power sequencer
    always_comb begin
        next_phy_state = phy_state;
        seq_start = 1'b0;
        seq_len = remote_wake_pkg::PD_CYCLES;
        case (phy_state)
            remote_wake_pkg::PHY_ON: begin
                if (deep_req) begin
                    next_phy_state = remote_wake_pkg::PHY_DOWN;
                    seq_start = 1'b1; // RULE_08
                end
            end
            remote_wake_pkg::PHY_DOWN: begin
                if (!seq_busy && !deep_req) begin
                    next_phy_state = remote_wake_pkg::PHY_STAB;
                    seq_start = 1'b1;
                    seq_len = remote_wake_pkg::TIMER_W'(STAB_CYCLES); // RULE_11
                end
            end
            remote_wake_pkg::PHY_STAB: begin
                if (!seq_busy) begin
                    next_phy_state = remote_wake_pkg::PHY_HOLD;
                    seq_start = 1'b1;
                    seq_len = remote_wake_pkg::RST_CYCLES; // RULE_13
                end
            end
            default: begin
                if (!seq_busy) begin
                    next_phy_state = remote_wake_pkg::PHY_ON;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            phy_state <= remote_wake_pkg::PHY_DOWN;
        end else begin
            phy_state <= next_phy_state;
        end
    end

    interval_timer #(.W(remote_wake_pkg::TIMER_W)) seq_timer ( // RULE_18
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(seq_start),
        .length_in(seq_len),
        .busy_out(seq_busy),
        .done_out()
    );

    // software reset pulse stretched to the minimum
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rst_release_q <= 1'b1;
        end else begin
            rst_release_q <= soft_rst.phy_rst_release;
        end
    end
    assign soft_start = rst_release_q && !soft_rst.phy_rst_release; // RULE_14

    interval_timer #(.W(remote_wake_pkg::TIMER_W)) soft_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(soft_start),
        .length_in(remote_wake_pkg::RST_CYCLES),
        .busy_out(soft_busy),
        .done_out()
    );

    assign osc_en_out = (phy_state != remote_wake_pkg::PHY_DOWN); // RULE_08
    assign pll_en_out = (phy_state != remote_wake_pkg::PHY_DOWN);
    assign bandgap_en_out = (phy_state != remote_wake_pkg::PHY_DOWN) && !bmcr_pd; // RULE_09
    // a low release during stabilisation keeps reset until it is raised
    assign phy_reset_out = (phy_state != remote_wake_pkg::PHY_ON) // RULE_12
        || !soft_rst.phy_rst_release || soft_busy;

    // events and interrupt
    assign evt_set[remote_wake_pkg::EVT_WAKE] = pme_start;
    assign evt_set[remote_wake_pkg::EVT_READY_EXIT] =
        (mode == remote_wake_pkg::MODE_READY) && (next_mode == remote_wake_pkg::MODE_NORMAL);
    assign evt_set[remote_wake_pkg::EVT_PHY_UP] =
        (phy_state == remote_wake_pkg::PHY_HOLD) && (next_phy_state == remote_wake_pkg::PHY_ON);

    // apb access
    assign setup = psel_in && !penable_in;
    assign wr_en = psel_in && penable_in && pwrite_in;
    assign pready_out = 1'b1;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            evt_status <= '0;
        end else if (wr_en && (paddr_in == remote_wake_pkg::EVT_CLEAR_ADDR)) begin
            evt_status <= (evt_status & ~pwdata_in[remote_wake_pkg::EVT_W-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg <= remote_wake_pkg::CFG_RESET;
            wake_ctrl <= remote_wake_pkg::WAKE_CTRL_RESET;
            soft_rst <= remote_wake_pkg::SOFT_RESET_RESET;
            evt_enable <= '0;
            bmcr_pd <= 1'b0;
        end else if (wr_en) begin
            if (paddr_in == remote_wake_pkg::CFG_WORD_ADDR) begin
                cfg <= pwdata_in[15:0];
                cfg.spare <= '0;
            end else if (paddr_in == remote_wake_pkg::WAKE_CTRL_ADDR) begin
                wake_ctrl <= pwdata_in[7:0];
                wake_ctrl.spare <= '0;
            end else if (paddr_in == remote_wake_pkg::EVT_ENABLE_ADDR) begin
                evt_enable <= pwdata_in[remote_wake_pkg::EVT_W-1:0];
            end else if (paddr_in == remote_wake_pkg::PHY_MODE_ADDR) begin
                bmcr_pd <= pwdata_in[remote_wake_pkg::BMCR_PD_BIT];
            end else if (paddr_in == remote_wake_pkg::SOFT_RESET_ADDR) begin
                soft_rst <= pwdata_in[7:0];
                soft_rst.spare <= '0;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr_in == remote_wake_pkg::CFG_WORD_ADDR) begin
            next_rdata[15:0] = cfg;
        end else if (paddr_in == remote_wake_pkg::WAKE_CTRL_ADDR) begin
            next_rdata[7:0] = wake_ctrl;
        end else if (paddr_in == remote_wake_pkg::EVT_STATUS_ADDR) begin
            next_rdata[remote_wake_pkg::EVT_W-1:0] = evt_status;
        end else if (paddr_in == remote_wake_pkg::EVT_CLEAR_ADDR) begin
            next_rdata = 32'h0000_0000;
        end else if (paddr_in == remote_wake_pkg::EVT_ENABLE_ADDR) begin
            next_rdata[remote_wake_pkg::EVT_W-1:0] = evt_enable;
        end else if (paddr_in == remote_wake_pkg::STATE_ADDR) begin
            next_rdata[5:0] = {phy_state, mode, pme_active, strap_q};
        end else if (paddr_in == remote_wake_pkg::PHY_MODE_ADDR) begin
            next_rdata[remote_wake_pkg::BMCR_PD_BIT] = bmcr_pd;
        end else if (paddr_in == remote_wake_pkg::SOFT_RESET_ADDR) begin
            next_rdata[7:0] = soft_rst;
        end else begin
            next_err = 1'b1;
        end
    end

    // answer prepared in the setup cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (setup) begin
            prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
            pslverr_out <= next_err;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(evt_status & evt_enable);
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence ready_wake_seq;
        mode == remote_wake_pkg::MODE_READY && ready_wake;
    endsequence
    sequence exit_seq;
        pme_active ##1 power_event_out && mode == remote_wake_pkg::MODE_NORMAL;
    endsequence

    static_hold_a: assert property (pme_active && cfg.wake_out_type_cfg |=> pme_active) // RULE_01
        else $error("static power event dropped before reset");
    strap_ready_a: assert property (mode == remote_wake_pkg::MODE_RESET && ready_ok // RULE_02
        |=> mode == remote_wake_pkg::MODE_READY && !usb_attach_en_out)
        else $error("ready mode not entered with strap high");
    strap_normal_a: assert property (mode == remote_wake_pkg::MODE_RESET && !ready_ok // RULE_03
        |=> usb_attach_en_out && usb_line_drive_en_out)
        else $error("normal mode not entered with strap low");
    ready_lines_a: assert property (mode == remote_wake_pkg::MODE_READY // RULE_05
        |-> !usb_line_drive_en_out && magic_det_en_out && autoneg_en_out && !deep_req)
        else $error("ready mode enables wrong");
    ready_exit_a: assert property (ready_wake_seq |=> exit_seq) // RULE_16
        else $error("ready wake did not raise event and exit");
    normal_wake_a: assert property (mode == remote_wake_pkg::MODE_NORMAL // RULE_06
        && usb_suspended_in && host_resume_in |=> remote_wake_req_out && pme_active)
        else $error("host resume did not wake");
    down_off_a: assert property (phy_state == remote_wake_pkg::PHY_DOWN // RULE_08
        |-> !osc_en_out && !pll_en_out && !bandgap_en_out && phy_reset_out)
        else $error("clocks running in full power-down");
    down_len_a: assert property ($rose(phy_state == remote_wake_pkg::PHY_DOWN) // RULE_18
        |-> (phy_state == remote_wake_pkg::PHY_DOWN)[*8])
        else $error("power-down too short");
    bmcr_pd_a: assert property (phy_state == remote_wake_pkg::PHY_ON && bmcr_pd // RULE_09
        |-> osc_en_out && pll_en_out && !bandgap_en_out)
        else $error("basic power-down wrong");
    stab_reset_a: assert property (phy_state == remote_wake_pkg::PHY_STAB // RULE_11
        |=> phy_reset_out)
        else $error("phy left reset during stabilisation");
    soft_len_a: assert property (soft_start |=> phy_reset_out[*8]) // RULE_14
        else $error("soft phy reset too short");
    ext_pulse_a: assert property (ext_s2 && !ext_s3 |=> ext_evt ##1 !ext_evt) // RULE_19
        else $error("external wake pulse not single event");
endmodule

// ===== logic/dummy_unused_marker.sv
// not used

// ===== verif/host_pmic_model.sv
// usb host and power management ic model facing the power event output
`timescale 1ns/1ps
module host_pmic_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // bench commands
    input wire logic resume_cmd_in,
    input wire logic suspend_cmd_in,
    // device side
    input wire logic power_event_in,
    output logic host_resume_out,
    output logic usb_suspended_out,
    output logic supply_on_out
);
    logic cmd_d = 1'b0;
    always_ff @(posedge clock_in) begin
        cmd_d <= resume_cmd_in;
        host_resume_out <= resume_cmd_in & ~cmd_d;
        usb_suspended_out <= suspend_cmd_in;
        supply_on_out <= ~rst_in & (supply_on_out | power_event_in);
    end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the remote wake and phy power sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
`define WAITFOR(c, m) for (n = 0; n < (m) && !(c); n++) @(posedge clock_in);
module tb_top;
    localparam int STAB_C = 300;
    localparam int MIN_C = 500 / 4;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic wol_strap_in = 1'b1;
    logic external_wake_in = 1'b1;
    logic pattern_match_in = 1'b0;
    logic magic_packet_in = 1'b0;
    logic link_chg_secondary_in = 1'b0, link_chg_primary_in = 1'b0;
    logic resume_cmd = 1'b0;
    logic suspend_cmd = 1'b0;
    logic host_resume_in, usb_suspended_in, supply_on, err, pready_out, pslverr_out;
    logic [31:0] prdata_out, rd;
    logic power_event_out, usb_line_drive_en_out, usb_attach_en_out, magic_det_en_out;
    logic autoneg_en_out, misc_func_en_out, osc_en_out, pll_en_out, phy_en_out;
    logic bandgap_en_out, phy_reset_out, irq_out;
    int err_total = 0;
    int n_tests = 0;
    int n, i, hs, s, off_cnt = 0, hot_cnt = 0;

    remote_wake_phy_power_seq #(.STAB_CYCLES(STAB_C)) DUT (
        .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .wol_strap_in, .external_wake_in,
        .pattern_match_in, .magic_packet_in, .link_chg_primary_in,
        .link_chg_secondary_in, .host_resume_in, .usb_suspended_in, .power_event_out,
        .remote_wake_req_out(), .usb_line_drive_en_out, .usb_attach_en_out,
        .magic_det_en_out, .phy_en_out, .autoneg_en_out, .misc_func_en_out,
        .osc_en_out, .pll_en_out, .bandgap_en_out, .phy_reset_out, .irq_out
    );
    host_pmic_model partner (
        .clock_in, .rst_in, .resume_cmd_in(resume_cmd), .suspend_cmd_in(suspend_cmd),
        .power_event_in(power_event_out), .host_resume_out(host_resume_in),
        .usb_suspended_out(usb_suspended_in), .supply_on_out(supply_on)
    );

    initial begin
        forever #2 clock_in = ~clock_in;
    end
    // oscillator-off cycles and reset cycles with clocks running
    always @(posedge clock_in) begin
        if (osc_en_out === 1'b0) off_cnt++;
        if (phy_reset_out === 1'b1 && osc_en_out === 1'b1) hot_cnt++;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        @(posedge clock_in);
        while (pready_out !== 1'b1) @(posedge clock_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic pulse(input int src);
        @(posedge clock_in);
        magic_packet_in <= (src == 0);
        link_chg_secondary_in <= (src == 1);
        external_wake_in <= (src != 2);
        pattern_match_in <= (src == 3);
        link_chg_primary_in <= (src == 4);
        repeat ((src == 2) ? 4 : 1) @(posedge clock_in);
        magic_packet_in <= 1'b0;
        link_chg_secondary_in <= 1'b0;
        external_wake_in <= 1'b1;
        pattern_match_in <= 1'b0;
        link_chg_primary_in <= 1'b0;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge clock_in);
        wol_strap_in <= strap;
        rst_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        hs = hot_cnt;
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        `CHK(magic_det_en_out & autoneg_en_out, 1'b1)
        `CHK(misc_func_en_out | usb_attach_en_out, 1'b0)
        rdx(remote_wake_pkg::CFG_WORD_ADDR, 32'h7001);
        rdx(remote_wake_pkg::SOFT_RESET_ADDR, 32'h1);
        apb(1'b0, 8'h3c, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // magic packet, secondary link change, external pin, enables all clear
        for (i = 0; i < 3; i++) begin
            if (i > 0) do_reset(1'b1);
            `CHK(usb_line_drive_en_out, 1'b0)
            `CHK(power_event_out, 1'b0)
            pulse(i);
            `WAITFOR(power_event_out === 1'b1, 20)
            `CHK(power_event_out, 1'b1)
            repeat (2) @(posedge clock_in);
            `CHK(usb_attach_en_out & usb_line_drive_en_out, 1'b1)
            repeat (300) @(posedge clock_in);
            `CHK(power_event_out & supply_on, 1'b1)
        end
        apb(1'b1, remote_wake_pkg::EVT_ENABLE_ADDR, 32'h1);
        repeat (2) @(posedge clock_in);
        `CHK(irq_out, 1'b1)
        apb(1'b1, remote_wake_pkg::EVT_ENABLE_ADDR, 32'h0);
        repeat (2) @(posedge clock_in);
        `CHK(irq_out, 1'b0)
        apb(1'b1, remote_wake_pkg::EVT_ENABLE_ADDR, 32'h1);
        apb(1'b1, remote_wake_pkg::EVT_CLEAR_ADDR, 32'h7);
        repeat (2) @(posedge clock_in);
        `CHK(irq_out, 1'b0)
        do_reset(1'b0);
        `CHK(usb_attach_en_out & usb_line_drive_en_out, 1'b1)
        `WAITFOR(phy_reset_out === 1'b0, 1000)
        `CHK(hot_cnt - hs >= STAB_C + MIN_C, 1'b1)
        suspend_cmd <= 1'b1;
        pulse(3);
        apb(1'b0, remote_wake_pkg::EVT_STATUS_ADDR, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b1, remote_wake_pkg::CFG_WORD_ADDR, 32'h7003);
        apb(1'b1, remote_wake_pkg::WAKE_CTRL_ADDR, 32'h9);
        pulse(3);
        apb(1'b0, remote_wake_pkg::EVT_STATUS_ADDR, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b1, remote_wake_pkg::WAKE_CTRL_ADDR, 32'hc);
        apb(1'b1, remote_wake_pkg::EVT_CLEAR_ADDR, 32'h7);
        pulse(4);
        apb(1'b0, remote_wake_pkg::EVT_STATUS_ADDR, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b1, remote_wake_pkg::WAKE_CTRL_ADDR, 32'h0);
        apb(1'b1, remote_wake_pkg::EVT_CLEAR_ADDR, 32'h7);
        resume_cmd <= 1'b1;
        repeat (2) @(posedge clock_in);
        apb(1'b0, remote_wake_pkg::EVT_STATUS_ADDR, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b1, remote_wake_pkg::PHY_MODE_ADDR, 32'h800);
        @(posedge clock_in);
        `CHK({osc_en_out, pll_en_out, bandgap_en_out}, 3'b110)
        apb(1'b1, remote_wake_pkg::PHY_MODE_ADDR, 32'h0);
        s = off_cnt;
        apb(1'b1, remote_wake_pkg::SOFT_RESET_ADDR, 32'h3);
        repeat (2) @(posedge clock_in);
        `CHK({osc_en_out, pll_en_out, bandgap_en_out, phy_en_out}, 4'h0)
        hs = hot_cnt;
        apb(1'b1, remote_wake_pkg::SOFT_RESET_ADDR, 32'h1);
        `WAITFOR(osc_en_out === 1'b1, 1000)
        `CHK(off_cnt - s >= MIN_C, 1'b1)
        `WAITFOR(phy_reset_out === 1'b0, 1000)
        `CHK(hot_cnt - hs >= STAB_C + MIN_C, 1'b1)
        hs = hot_cnt;
        apb(1'b1, remote_wake_pkg::SOFT_RESET_ADDR, 32'h0);
        apb(1'b1, remote_wake_pkg::SOFT_RESET_ADDR, 32'h1);
        `WAITFOR(phy_reset_out === 1'b0, 1000)
        `CHK(hot_cnt - hs >= MIN_C, 1'b1)
        end_of_test();
    end
endmodule
